// >>> pkg/display_power_pkg.sv
package display_power_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONFIG = 8'h95;
    localparam logic [7:0] IDX_SEG_LO = 8'h97;
    localparam logic [7:0] IDX_VOLT = 8'h9C;
    localparam logic [7:0] IDX_PTR = 8'hAC;
    localparam logic [7:0] IDX_DATA = 8'hAE;
    localparam logic [7:0] IDX_CONFIG_Y = 8'hB1;
    localparam logic [7:0] IDX_STATUS = 8'hC0;
    localparam logic [7:0] IDX_SEG_HI = 8'hED;

    // display_config fields
    localparam int CFG_EN_BIT = 7;
    localparam int CFG_PSOFF_BIT = 6;
    localparam int CFG_THIRD_BIT = 2;
    localparam int CFG_MUX_LSB = 0;
    localparam logic [1:0] MUX_4X = 2'h3;

    // display_voltage_config fields
    localparam int VOLT_LADDER_BIT = 7;
    localparam int BIAS_LVL_W = 6;

    // display_config_y, pointer and status fields
    localparam int Y_FREEZE_BIT = 0;
    localparam int PTR_WR_BIT = 7;
    localparam int PTR_SCREEN_LSB = 4;
    localparam int PTR_ADDR_W = 4;
    localparam int ST_ON_BIT = 0;
    localparam int ST_PUMP_BIT = 1;
    localparam int ST_FROZEN_BIT = 2;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] VREF_DEFAULT = 8'h40;

    // display memory and segment line layout
    localparam int SCREENS = 4;
    localparam int MEM_BYTES = 15;
    localparam int FRAME_W = MEM_BYTES * 8;
    localparam int SEG_ALWAYS = 16;
    localparam int SEG_LINES = 29;
    localparam int SEG_SHARED_A = 27;
    localparam int SEG_SHARED_B = 28;
    localparam int SEG_HI_W = SEG_LINES - SEG_ALWAYS - 8;

    typedef struct packed {
        logic [7:0] level_a;
        logic [7:0] level_b;
        logic [7:0] level_c;
    } wave_levels_t;

    typedef struct packed {
        logic display_on;
        logic pump_en;
        logic ladder_sel;
    } supply_ctrl_t;

endpackage : display_power_pkg

// >>> design/display_power_ctrl.sv
// Overview of operation
// - With the charge pump chosen and the display disabled, waveform generation is fully off.
// - A 6-bit contrast bias level in display_voltage_config gives 64 levels for the pump.
// - The three waveform levels follow from the reference, the bias level and the bias ratio.
// - The ladder source select bit resets to zero, so the charge pump is the default source.
// - With ladder source selected, levels come from the external ladder and bias has no effect.
// - In deepest power save the display shows only when off-bit is 0 and enable bit is 1.
// - Configuration and display memory are kept unchanged while the display is off.
// - Segment lines 0 to 15 are always given to the display.
// - With 4x multiplexing the pins shared with commons 2 and 3 are not segment lines.
// - Segment lines above 15 work only when enabled in the two segment enable registers.
// - A freeze bit holds the shown image while display memory is being rewritten.
// - A pointer write with top bit set copies the data register into display memory.
// - A pointer write with top bit clear loads the addressed memory byte into the data register.
// - Display memory holds four screens of 15 bytes, even lines low nibble, odd lines high.
//
// The APB interface to the registers is this design's own decision.
module display_power_ctrl
    import display_power_pkg::*;
#(
    parameter logic [7:0] VREF_CODE = VREF_DEFAULT
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [9:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // power mode and screen choice
    input wire logic DEEP_SLEEP,
    input wire logic [1:0] SCREEN_SEL,
    // supply and glass side
    output supply_ctrl_t SUPPLY,
    output wave_levels_t WAVE_LEVELS,
    output logic [SEG_LINES-1:0] SEG_FUNC_EN,
    output logic [3:0] COM_ACTIVE,
    output logic [FRAME_W-1:0] SEG_STATE
);

    logic [7:0] cfg_q;
    logic [7:0] seg_lo_q;
    logic [7:0] seg_hi_q;
    logic [7:0] volt_q;
    logic [7:0] cfg_y_q;
    logic [7:0] ptr_q;
    logic [7:0] data_q;
    logic [7:0] mem_q [SCREENS*MEM_BYTES];
    logic [FRAME_W-1:0] frame_q;
    logic [31:0] rdata_q;
    supply_ctrl_t supply_q;
    wave_levels_t levels_q;

    logic [7:0] index;
    logic setup;
    logic wr_access;
    logic mapped;
    logic disp_on_d;
    logic pump_d;
    logic ladder;
    logic freeze;
    logic mux4;
    logic [1:0] ptr_screen;
    logic [PTR_ADDR_W-1:0] ptr_addr;
    logic ptr_valid;
    wave_levels_t levels_d;

    function automatic int mem_index(input logic [1:0] scr, input logic [PTR_ADDR_W-1:0] adr);
        mem_index = int'(scr) * MEM_BYTES + int'(adr);
    endfunction : mem_index

    // levels from reference, bias level and ratio
    function automatic wave_levels_t calc_levels(input logic [7:0] vref,
                                                 input logic [BIAS_LVL_W-1:0] lvl,
                                                 input logic third);
        logic [9:0] top;
        wave_levels_t r;
        top = {2'h0, vref} + {4'h0, lvl};
        r.level_c = top[7:0];
        if (third) begin
            r.level_a = 8'((top * 10'h001) / 10'h003);
            r.level_b = 8'((top * 10'h002) / 10'h003);
        end else begin
            r.level_a = 8'(top >> 1);
            r.level_b = 8'(top >> 1);
        end
        calc_levels = r;
    endfunction : calc_levels

    assign index = PADDR[9:2];
    assign setup = PSEL && !PENABLE;
    assign wr_access = PSEL && PENABLE && PWRITE && mapped;
    assign ladder = volt_q[VOLT_LADDER_BIT];
    assign freeze = cfg_y_q[Y_FREEZE_BIT];
    assign mux4 = (cfg_q[CFG_MUX_LSB +: 2] == MUX_4X);
    assign ptr_screen = PWDATA[PTR_SCREEN_LSB +: 2];
    assign ptr_addr = PWDATA[PTR_ADDR_W-1:0];
    assign ptr_valid = (int'(ptr_addr) < MEM_BYTES);

    always_comb begin
        unique case (index)
            IDX_CONFIG, IDX_SEG_LO, IDX_VOLT, IDX_PTR, IDX_DATA,
            IDX_CONFIG_Y, IDX_STATUS, IDX_SEG_HI: mapped = (PADDR[1:0] == 2'h0);
            default: mapped = 1'b0;
        endcase
    end

    // zero wait state slave; unmapped addresses answer with an error
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign PRDATA = rdata_q;

    // read data captured in the setup cycle so it stands in the access phase
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_q <= 32'h0000_0000;
        end else if (setup) begin
            unique case (index)
                IDX_CONFIG: rdata_q <= {24'h00_0000, cfg_q};
                IDX_SEG_LO: rdata_q <= {24'h00_0000, seg_lo_q};
                IDX_VOLT: rdata_q <= {24'h00_0000, volt_q};
                IDX_PTR: rdata_q <= {24'h00_0000, ptr_q};
                IDX_DATA: rdata_q <= {24'h00_0000, data_q};
                IDX_CONFIG_Y: rdata_q <= {24'h00_0000, cfg_y_q};
                IDX_SEG_HI: rdata_q <= {24'h00_0000, seg_hi_q};
                IDX_STATUS: rdata_q <= {29'h0000_0000, freeze, supply_q.pump_en,
                                        supply_q.display_on};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ladder select resets to zero, charge pump by default
    // configuration changes only through software writes
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cfg_q <= REG_RESET;
            seg_lo_q <= REG_RESET;
            seg_hi_q <= REG_RESET;
            volt_q <= REG_RESET;
            cfg_y_q <= REG_RESET;
            ptr_q <= REG_RESET;
        end else if (wr_access) begin
            unique case (index)
                IDX_CONFIG: cfg_q <= PWDATA[7:0];
                IDX_SEG_LO: seg_lo_q <= PWDATA[7:0];
                IDX_VOLT: volt_q <= PWDATA[7:0];
                IDX_SEG_HI: seg_hi_q <= {{(8-SEG_HI_W){1'b0}}, PWDATA[SEG_HI_W-1:0]};
                IDX_CONFIG_Y: cfg_y_q <= PWDATA[7:0];
                IDX_PTR: ptr_q <= PWDATA[7:0];
                default: ;
            endcase
        end
    end

    // pointer read loads the data register; a direct write also lands here
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            data_q <= REG_RESET;
        end else if (wr_access && index == IDX_DATA) begin
            data_q <= PWDATA[7:0];
        end else if (wr_access && index == IDX_PTR && !PWDATA[PTR_WR_BIT] && ptr_valid) begin
            data_q <= mem_q[mem_index(ptr_screen, ptr_addr)];
        end
    end

    // pointer write copies the data register into memory
    // four screens of fifteen bytes, addresses above 14 ignored
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < SCREENS * MEM_BYTES; i++) begin
                mem_q[i] <= REG_RESET;
            end
        end else if (wr_access && index == IDX_PTR && PWDATA[PTR_WR_BIT] && ptr_valid) begin
            mem_q[mem_index(ptr_screen, ptr_addr)] <= data_q;
        end
    end

    // shown image follows memory only while not frozen
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            frame_q <= '0;
        end else if (!freeze) begin
            for (int b = 0; b < MEM_BYTES; b++) begin
                frame_q[b*8 +: 8] <= mem_q[mem_index(SCREEN_SEL, PTR_ADDR_W'(b))];
            end
        end
    end
    assign SEG_STATE = frame_q;

    // deep sleep shows the display only with off-bit clear and enable set
    always_comb begin
        if (DEEP_SLEEP) begin
            disp_on_d = !cfg_q[CFG_PSOFF_BIT] && cfg_q[CFG_EN_BIT];
        end else begin
            disp_on_d = cfg_q[CFG_EN_BIT];
        end
    end

    // pump only when shown and the ladder is not chosen
    assign pump_d = disp_on_d && !ladder;

    // bias level feeds the pump levels
    // ladder source leaves bias without effect
    always_comb begin
        if (pump_d) begin
            levels_d = calc_levels(VREF_CODE, volt_q[BIAS_LVL_W-1:0], cfg_q[CFG_THIRD_BIT]);
        end else begin
            levels_d = '0;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            supply_q <= '0;
            levels_q <= '0;
        end else begin
            supply_q.display_on <= disp_on_d;
            supply_q.pump_en <= pump_d;
            supply_q.ladder_sel <= ladder && disp_on_d;
            levels_q <= levels_d;
        end
    end
    assign SUPPLY = supply_q;
    assign WAVE_LEVELS = levels_q;

    // upper lines need their enable bits
    // shared pins drop out under 4x multiplexing
    always_comb begin
        SEG_FUNC_EN = {seg_hi_q[SEG_HI_W-1:0], seg_lo_q, {SEG_ALWAYS{1'b1}}};
        if (mux4) begin
            SEG_FUNC_EN[SEG_SHARED_A] = 1'b0;
            SEG_FUNC_EN[SEG_SHARED_B] = 1'b0;
        end
        unique case (cfg_q[CFG_MUX_LSB +: 2])
            MUX_4X: COM_ACTIVE = 4'hF;
            2'h2: COM_ACTIVE = 4'h7;
            2'h1: COM_ACTIVE = 4'h3;
            default: COM_ACTIVE = 4'h1;
        endcase
    end

    AST_PUMP_OFF_WHEN_DISABLED: assert property (@(posedge CLK) disable iff (!RESETN)
        !cfg_q[CFG_EN_BIT] |=> !SUPPLY.pump_en && WAVE_LEVELS == '0)
        else $error("pump or levels active with display disabled");

    AST_BIAS_LEVEL_C: assert property (@(posedge CLK) disable iff (!RESETN)
        pump_d |=> WAVE_LEVELS.level_c == 8'(VREF_CODE + $past(volt_q[BIAS_LVL_W-1:0])))
        else $error("level c does not follow the bias level");

    AST_RATIO_LEVELS: assert property (@(posedge CLK) disable iff (!RESETN)
        pump_d && !cfg_q[CFG_THIRD_BIT] |=> WAVE_LEVELS.level_a == WAVE_LEVELS.level_b)
        else $error("half bias levels differ");

    AST_LADDER_NO_BIAS: assert property (@(posedge CLK) disable iff (!RESETN)
        ladder ##1 $stable(ladder) |-> !SUPPLY.pump_en && WAVE_LEVELS == '0)
        else $error("pump levels present with ladder chosen");

    AST_DEEP_SLEEP_OFF: assert property (@(posedge CLK) disable iff (!RESETN)
        DEEP_SLEEP && cfg_q[CFG_PSOFF_BIT] |=> !SUPPLY.display_on)
        else $error("display on in deep sleep with off-bit set");

    AST_RETAIN_WHILE_OFF: assert property (@(posedge CLK) disable iff (!RESETN)
        !SUPPLY.display_on && !wr_access |=> $stable(cfg_q) && $stable(volt_q) && $stable(seg_lo_q))
        else $error("configuration changed without a write");

    AST_LOW_LINES_FIXED: assert property (@(posedge CLK) disable iff (!RESETN)
        SEG_FUNC_EN[SEG_ALWAYS-1:0] == {SEG_ALWAYS{1'b1}})
        else $error("low segment line not dedicated");

    AST_MUX4_SHARED: assert property (@(posedge CLK) disable iff (!RESETN)
        mux4 |-> COM_ACTIVE == 4'hF && !SEG_FUNC_EN[SEG_SHARED_A] && !SEG_FUNC_EN[SEG_SHARED_B])
        else $error("shared pin used as segment under 4x");

    AST_UPPER_ENABLE: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_access && index == IDX_SEG_LO |=> SEG_FUNC_EN[SEG_ALWAYS +: 8] == $past(PWDATA[7:0]))
        else $error("upper segment enable not applied");

    AST_FREEZE_HOLDS: assert property (@(posedge CLK) disable iff (!RESETN)
        freeze ##1 freeze |-> $stable(SEG_STATE))
        else $error("shown image changed while frozen");

    AST_MEM_WRITE: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_access && index == IDX_PTR && PWDATA[PTR_WR_BIT] && ptr_valid
        |=> mem_q[mem_index($past(ptr_screen), $past(ptr_addr))] == $past(data_q))
        else $error("pointer write did not store data");

    AST_MEM_READ: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_access && index == IDX_PTR && !PWDATA[PTR_WR_BIT] && ptr_valid
        |=> data_q == $past(mem_q[mem_index(ptr_screen, ptr_addr)]))
        else $error("pointer read did not load data");

    AST_PUMP_CONDITION: assert property (@(posedge CLK) disable iff (!RESETN)
        SUPPLY.pump_en |-> SUPPLY.display_on && !$past(ladder))
        else $error("pump on without its conditions");

endmodule : display_power_ctrl

// >>> tb/glass_panel_model.sv
module glass_panel_model
    import display_power_pkg::*;
(
    // drive from the controller
    input wire supply_ctrl_t supply,
    input wire wave_levels_t levels,
    input wire logic [SEG_LINES-1:0] seg_en,
    input wire logic [3:0] com,
    input wire logic [FRAME_W-1:0] image,
    // internal reference seen by the pump
    input wire logic reference_on,
    // what a viewer sees
    output logic [FRAME_W-1:0] lit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic powered;
    logic [SEG_LINES:0] en_x;
    // the last byte has no odd line, so pad the enables to keep the lookup defined
    assign en_x = {1'b0, seg_en};
    // a pump with no level set or no reference leaves the glass dark
    assign powered = supply.display_on &
        (supply.ladder_sel | (supply.pump_en & reference_on & (levels.level_c != 8'h00)));
    always_comb begin
        for (int i = 0; i < FRAME_W; i++) begin
            lit[i] = powered & image[i] & en_x[(i / 8) * 2 + (i % 8) / 4] & com[i % 4];
        end
    end
endmodule : glass_panel_model

// >>> tb/tb.sv
module tb
    import display_power_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] VREF = 8'h40;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic deep_sleep = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] screen_sel = 2'h0;
    logic reference_keep_alive = 1'b0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic err;
    supply_ctrl_t supply;
    wave_levels_t levels;
    logic [SEG_LINES-1:0] seg_en;
    logic [3:0] com;
    logic [FRAME_W-1:0] seg_state;
    logic [FRAME_W-1:0] lit;
    logic [FRAME_W-1:0] frame;
    int num_errors = 0;
    int comparisons = 0;

    always #2 clk = ~clk;

    display_power_ctrl #(.VREF_CODE(VREF)) display_power_ctrl_inst (
        .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .DEEP_SLEEP(deep_sleep), .SCREEN_SEL(screen_sel), .SUPPLY(supply),
        .WAVE_LEVELS(levels), .SEG_FUNC_EN(seg_en), .COM_ACTIVE(com), .SEG_STATE(seg_state));

    glass_panel_model glass_panel_model_inst (
        .supply(supply), .levels(levels), .seg_en(seg_en), .com(com), .image(seg_state),
        .reference_on(reference_keep_alive | ~deep_sleep), .lit(lit));

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        // no local limit: only the watchdog ends a wait that never answers
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        chk(pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask : rchk

    task automatic settle;
        repeat (3) @(posedge clk);
    endtask : settle

    function automatic wave_levels_t exp_lv(input logic [5:0] b, input logic third);
        logic [7:0] c;
        c = VREF + {2'b00, b};
        return third ? {c / 8'd3, (c * 8'd2) / 8'd3, c} : {c >> 1, c >> 1, c};
    endfunction : exp_lv

    task automatic t_reset;
        chk(supply, 3'b000);
        chk(seg_en, 29'h0000FFFF);
        chk(com, 4'h1);
        rchk(IDX_VOLT, 8'h00);
        rchk(IDX_CONFIG, 8'h00);
        apb(1'b1, 8'h10, 8'hFF);
        chk(err, 1'b1);
        rchk(8'h10, 8'h00);
        chk(err, 1'b1);
        $display("test reset done");
    endtask : t_reset

    task automatic t_levels;
        logic [5:0] b;
        logic t;
        for (int i = 0; i < 6; i++) begin
            b = (i % 3 == 0) ? 6'h00 : ((i % 3 == 1) ? 6'h2E : 6'h3F);
            t = (i >= 3);
            apb(1'b1, IDX_VOLT, {2'b00, b});
            apb(1'b1, IDX_CONFIG, {5'h10, t, 2'h3});
            settle();
            chk(levels, exp_lv(b, t));
            chk(supply, 3'b110);
        end
        rchk(IDX_STATUS, 8'h03);
        apb(1'b1, IDX_VOLT, 8'hBF);
        settle();
        chk(supply, 3'b101);
        chk(levels, 24'h0);
        apb(1'b1, IDX_VOLT, 8'h3F);
        apb(1'b1, IDX_CONFIG, 8'h07);
        settle();
        chk({supply, levels}, 27'h0);
        $display("test levels done");
    endtask : t_levels

    task automatic t_sleep;
        // reference kept alive before deep sleep
        reference_keep_alive <= 1'b1;
        deep_sleep <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, IDX_CONFIG, {i[0], i[1], 6'h03});
            settle();
            chk(supply.display_on, i[0] & ~i[1]);
            chk(supply.pump_en, i[0] & ~i[1]);
        end
        deep_sleep <= 1'b0;
        settle();
        chk(supply.display_on, 1'b1);
        $display("test sleep done");
    endtask : t_sleep

    task automatic t_segs;
        logic [3:0] ce [4];
        ce = '{4'h1, 4'h3, 4'h7, 4'hF};
        apb(1'b1, IDX_SEG_LO, 8'hA5);
        apb(1'b1, IDX_SEG_HI, 8'hFF);
        rchk(IDX_SEG_HI, 8'h1F);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, IDX_CONFIG, {6'h00, m[1:0]});
            settle();
            chk(com, ce[m]);
            if (m == 1) chk(seg_en, {5'h1F, 8'hA5, 16'hFFFF});
            if (m == 3) chk(seg_en, {5'h07, 8'hA5, 16'hFFFF});
        end
        $display("test segments done");
    endtask : t_segs

    task automatic t_mem;
        screen_sel <= 2'h2;
        apb(1'b1, IDX_CONFIG_Y, 8'h01);
        for (int b = 0; b < 15; b++) begin
            frame[b * 8 +: 8] = {b[3:0], ~b[3:0]};
            apb(1'b1, IDX_DATA, {b[3:0], ~b[3:0]});
            apb(1'b1, IDX_PTR, {4'hA, b[3:0]});
        end
        apb(1'b1, IDX_DATA, 8'h5A);
        apb(1'b1, IDX_PTR, 8'h90);
        apb(1'b1, IDX_DATA, 8'hEE);
        apb(1'b1, IDX_PTR, 8'hAF);
        settle();
        chk(seg_state, '0);
        apb(1'b1, IDX_CONFIG_Y, 8'h00);
        apb(1'b1, IDX_CONFIG, 8'h87);
        settle();
        chk(seg_state, frame);
        apb(1'b1, IDX_PTR, 8'h10);
        rchk(IDX_DATA, 8'h5A);
        rchk(IDX_PTR, 8'h10);
        screen_sel <= 2'h1;
        settle();
        chk(lit[7:0], 8'h5A);
        $display("test memory done");
    endtask : t_mem

    task automatic t_keep;
        apb(1'b1, IDX_CONFIG, 8'h43);
        settle();
        chk(supply, 3'b000);
        rchk(IDX_CONFIG, 8'h43);
        rchk(IDX_VOLT, 8'h3F);
        rchk(IDX_SEG_LO, 8'hA5);
        apb(1'b1, IDX_PTR, 8'h23);
        rchk(IDX_DATA, frame[31:24]);
        $display("test retention done");
    endtask : t_keep

    task automatic wrap_up;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_levels();
        t_sleep();
        t_segs();
        t_mem();
        t_keep();
        wrap_up();
    end

    initial begin
        #40000;
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up();
    end
endmodule : tb
